/* rtl/eer_dev.sv */
`timescale 1ns/1ps
module eer_dev
	import eer_pkg::*;
#(
	parameter int unsigned INIT_CYC  = INIT_CYCLES,
	parameter int unsigned WRITE_CYC = WRITE_CYCLES
) (
	// clock, reset, freeze
	input  wire logic SYS_CLK,
	input  wire logic RST_N,
	input  wire logic CLK_EN,
	// two-wire bus
	eer_if.dev        BUS,
	// supply monitor
	input  wire logic LOW_SUPPLY,
	// status
	output logic      READY,
	output logic      BUSY,
	output logic      WR_DONE,
	output logic      WR_CANCEL
);

	typedef enum logic [2:0] {
		ST_INIT, ST_IDLE, ST_ADDR, ST_WORD, ST_DATA, ST_READ, ST_WAIT, ST_WRITE
	} eer_dev_state_t;

	eer_dev_state_t state;
	eer_dev_state_t nxt;
	logic [2:0]     scl_s;
	logic [2:0]     sda_s;
	logic [2:0]     low_s;
	logic           scl_f;
	logic           sda_f;
	logic           low_f;
	logic           scl_q;
	logic           sda_q;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_c;
	logic           stop_c;
	logic [3:0]     bit_cnt;
	logic [7:0]     shreg;
	logic [7:0]     addr;
	logic [7:0]     wbase;
	logic [7:0]     page_vld;
	logic           boundary;
	logic           mack;
	logic           sda_oe_n;
	logic           sda_o;
	logic [31:0]    timer;
	logic           take_data;
	logic           write_end;
	logic [7:0]     rd_byte;
	logic [7:0]     page [PAGE_BYTES];
	logic [7:0]     mem [MEM_WORDS];

	////////////////////////////////////////////////////////////////////////////////
	// pin sampling

	// three stages; the first is only read by the second
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_s <= SYNC_HIGH;
			sda_s <= SYNC_HIGH;
			low_s <= SYNC_LOW;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			low_f <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (CLK_EN) begin
			scl_s <= {scl_s[1:0], BUS.scl};
			sda_s <= {sda_s[1:0], BUS.sda};
			low_s <= {low_s[1:0], LOW_SUPPLY};
			scl_f <= eer_agree(scl_s, scl_f);
			sda_f <= eer_agree(sda_s, sda_f);
			low_f <= eer_agree(low_s, low_f);
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	// bus events, valid anywhere in a transfer
	assign scl_rise = scl_f & ~scl_q;
	assign scl_fall = ~scl_f & scl_q;
	assign start_c  = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_c   = scl_f & scl_q & ~sda_q & sda_f;

	// byte strobes for the page buffer and the array
	assign take_data = (state == ST_DATA) && scl_fall && (bit_cnt == BIT_ACK);
	assign write_end = (state == ST_WRITE) && (timer == 32'h0);
	assign rd_byte   = mem[addr];
	assign wbase     = {addr[7:3], 3'h0};

	////////////////////////////////////////////////////////////////////////////////
	// protocol engine

	// no reset pin on the bus side: only RST_N (power-on clear) and bus conditions
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state     <= ST_INIT;
			nxt       <= ST_IDLE;
			bit_cnt   <= 4'h0;
			shreg     <= BYTE_ZERO;
			addr      <= BYTE_ZERO;
			page_vld  <= BYTE_ZERO;
			boundary  <= 1'b0;
			mack      <= 1'b1;
			sda_oe_n  <= 1'b1;
			timer     <= 32'(INIT_CYC);
			WR_DONE   <= 1'b0;
			WR_CANCEL <= 1'b0;
		end else if (CLK_EN) begin
			WR_DONE   <= 1'b0;
			WR_CANCEL <= 1'b0;
			case (state)
			ST_INIT: begin
				// deaf to the bus until the count runs out
				if (timer == 32'h0) begin
					state <= ST_IDLE;
				end else begin
					timer <= timer - 32'h1;
				end
			end
			ST_WRITE: begin
				// no acknowledge, no start detection while the array is busy
				if (write_end) begin
					state    <= ST_IDLE;
					page_vld <= BYTE_ZERO;
					WR_DONE  <= 1'b1;
				end else begin
					timer <= timer - 32'h1;
				end
			end
			default: begin
				if (start_c) begin
					state    <= ST_ADDR;
					bit_cnt  <= 4'h0;
					sda_oe_n <= 1'b1;
					boundary <= 1'b0;
				end else if (stop_c) begin
					bit_cnt  <= 4'h0;
					sda_oe_n <= 1'b1;
					boundary <= 1'b0;
					if (state == ST_DATA && boundary && page_vld != BYTE_ZERO) begin
						if (low_f) begin
							state     <= ST_IDLE;
							page_vld  <= BYTE_ZERO;
							WR_CANCEL <= 1'b1;
						end else begin
							state <= ST_WRITE;
							timer <= 32'(WRITE_CYC) - 32'h1;
						end
					end else begin
						state    <= ST_IDLE;
						page_vld <= BYTE_ZERO;
					end
				end else if (state != ST_IDLE && state != ST_WAIT) begin
					if (scl_rise && bit_cnt != BIT_END) begin
						bit_cnt  <= bit_cnt + 4'h1;
						// a stop's own scl rise must not clear the ack boundary
						boundary <= boundary && (bit_cnt == 4'h0);
						if (state != ST_READ) begin
							shreg <= {shreg[6:0], sda_f};
						end
						if (bit_cnt == BIT_ACK) begin
							mack <= sda_f;
						end
					end else if (scl_fall && bit_cnt == BIT_ACK) begin
						// byte complete: decide the acknowledge
						case (state)
						ST_ADDR: begin
							if (shreg[7:1] == DEV_SEL) begin
								sda_oe_n <= 1'b0;
								nxt      <= shreg[0] ? ST_READ : ST_WORD;
							end else begin
								state <= ST_WAIT;
							end
						end
						ST_WORD: begin
							addr     <= shreg;
							page_vld <= BYTE_ZERO;
							sda_oe_n <= 1'b0;
							nxt      <= ST_DATA;
						end
						ST_DATA: begin
							// low bits roll over inside the page
							page_vld[addr[2:0]] <= 1'b1;
							addr                <= {addr[7:3], addr[2:0] + 3'h1};
							sda_oe_n            <= 1'b0;
							nxt                 <= ST_DATA;
						end
						ST_READ: begin
							sda_oe_n <= 1'b1; // release for host ack
							addr     <= addr + 8'h01;
						end
						default: begin
							sda_oe_n <= 1'b1;
						end
						endcase
					end else if (scl_fall && bit_cnt == BIT_END) begin
						bit_cnt <= 4'h0;
						if (state == ST_READ) begin
							if (mack) begin
								state    <= ST_WAIT;
								sda_oe_n <= 1'b1;
							end else begin
								shreg    <= rd_byte;
								sda_oe_n <= rd_byte[7];
							end
						end else begin
							state    <= nxt;
							boundary <= (state == ST_DATA);
							if (nxt == ST_READ) begin
								shreg    <= rd_byte;
								sda_oe_n <= rd_byte[7];
							end else begin
								sda_oe_n <= 1'b1;
							end
						end
					end else if (scl_fall && state == ST_READ) begin
						sda_oe_n <= shreg[3'(4'h7 - bit_cnt)];
					end else if (scl_fall) begin
						boundary <= 1'b0;
					end
				end
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// page buffer and array, no reset so they map to memory

	always_ff @(posedge SYS_CLK) begin
		if (CLK_EN) begin
			if (take_data) begin
				page[addr[2:0]] <= shreg;
			end
			if (write_end) begin
				for (int i = 0; i < PAGE_BYTES; i++) begin
					if (page_vld[i]) begin
						mem[wbase | 8'(i)] <= page[i];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin and status outputs

	// data output is a constant low; only the enable moves
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sda_o <= 1'b0;
			READY <= 1'b0;
			BUSY  <= 1'b0;
		end else if (CLK_EN) begin
			sda_o <= 1'b0;
			READY <= (state != ST_INIT);
			BUSY  <= (state == ST_WRITE);
		end
	end

	assign BUS.dev_sda_o    = sda_o;
	assign BUS.dev_sda_oe_n = sda_oe_n;

endmodule

/* rtl/eer_pkg.sv */
package eer_pkg;

	// clock rate and derived counts
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
	localparam int unsigned WRITE_TIME_US = 5000;
	localparam int unsigned WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
	localparam int unsigned INIT_TIME_US  = 100;
	localparam int unsigned INIT_CYCLES   = INIT_TIME_US * CLK_MHZ;

	// scl made by the host: four quarter ticks per bit
	localparam int unsigned SCL_PERIOD_NS = 1000;
	localparam logic [7:0]  QTR_CYCLES    = 8'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));

	// bit positions inside a nine-clock slot
	localparam logic [3:0]  BIT_ACK       = 4'h8;
	localparam logic [3:0]  BIT_END       = 4'h9;
	localparam int unsigned DUMMY_CLOCKS  = 9;
	localparam logic [3:0]  DUMMY_LAST    = 4'(DUMMY_CLOCKS - 1);

	// slave select, page and array sizes
	localparam logic [6:0]  DEV_SEL       = 7'h50;
	localparam int unsigned PAGE_BYTES    = 8;
	localparam int unsigned MEM_WORDS     = 256;

	// values after reset
	localparam logic [2:0]  SYNC_HIGH     = 3'h7;
	localparam logic [2:0]  SYNC_LOW      = 3'h0;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;

	// host command kinds
	localparam logic [1:0]  KIND_RECOVER  = 2'h0;
	localparam logic [1:0]  KIND_WRITE    = 2'h1;
	localparam logic [1:0]  KIND_READ     = 2'h2;

	// a pin level counts once the second and third stage agree
	function automatic logic eer_agree(input logic [2:0] s, input logic cur);
		return (s[1] == s[2]) ? s[2] : cur;
	endfunction

endpackage

/* rtl/eer_if.sv */
`timescale 1ns/1ps
interface eer_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic sda;

	// wired-and with pull-up: a released end reads as high
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
	modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

/* rtl/eer_host.sv */
`timescale 1ns/1ps
module eer_host
	import eer_pkg::*;
#(
	parameter int unsigned INIT_CYC = INIT_CYCLES
) (
	// clock, reset, freeze
	input  wire logic       SYS_CLK,
	input  wire logic       RST_N,
	input  wire logic       CLK_EN,
	// two-wire bus
	eer_if.host             BUS,
	// command
	input  wire logic       CMD_VALID,
	input  wire logic [1:0] CMD_KIND,
	input  wire logic [7:0] CMD_ADDR,
	input  wire logic [7:0] CMD_DATA,
	output logic            CMD_READY,
	// response
	output logic            RSP_VALID,
	output logic [7:0]      RSP_DATA,
	output logic            RSP_NACK
);

	typedef enum logic [1:0] {MS_WAIT, MS_IDLE, MS_RUN} eer_host_state_t;
	typedef enum logic [2:0] {ACT_START, ACT_STOP, ACT_TX, ACT_RX, ACT_DUMMY, ACT_END} eer_act_t;

	eer_host_state_t state;
	eer_act_t        act;
	logic [1:0]      kind;
	logic            auto_run;
	logic [2:0]      step;
	logic [1:0]      quarter;
	logic [3:0]      bitn;
	logic [7:0]      qcnt;
	logic [31:0]     timer;
	logic [7:0]      c_addr;
	logic [7:0]      c_data;
	logic [7:0]      txb;
	logic [7:0]      rxb;
	logic            nack;
	logic            scl;
	logic            sda_oe_n;
	logic            sda_o;
	logic [2:0]      sda_s;
	logic            sda_f;
	logic            tick;

	// sequence of bus actions per command kind
	function automatic eer_act_t step_act(input logic [1:0] k, input logic [2:0] s);
		eer_act_t a;
		a = ACT_END;
		if (k == KIND_RECOVER) begin
			case (s)
			3'h0:    a = ACT_START;
			3'h1:    a = ACT_DUMMY;
			3'h2:    a = ACT_START;
			3'h3:    a = ACT_STOP;
			default: a = ACT_END;
			endcase
		end else if (k == KIND_WRITE) begin
			case (s)
			3'h0:    a = ACT_START;
			3'h1:    a = ACT_TX;
			3'h2:    a = ACT_TX;
			3'h3:    a = ACT_TX;
			3'h4:    a = ACT_STOP;
			default: a = ACT_END;
			endcase
		end else begin
			// random read: dummy write, then restart with read
			case (s)
			3'h0:    a = ACT_START;
			3'h1:    a = ACT_TX;
			3'h2:    a = ACT_TX;
			3'h3:    a = ACT_START;
			3'h4:    a = ACT_TX;
			3'h5:    a = ACT_RX;
			3'h6:    a = ACT_STOP;
			default: a = ACT_END;
			endcase
		end
		return a;
	endfunction

	assign act  = step_act(kind, step);
	assign tick = (qcnt == 8'h00);
	assign txb  = (step == 3'h1) ? {DEV_SEL, 1'b0} :
	              (step == 3'h2) ? c_addr :
	              (kind == KIND_WRITE) ? c_data : {DEV_SEL, 1'b1};

	////////////////////////////////////////////////////////////////////////////////
	// sda sampling and quarter tick

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sda_s <= SYNC_HIGH;
			sda_f <= 1'b1;
			qcnt  <= QTR_CYCLES - 8'h01;
		end else if (CLK_EN) begin
			sda_s <= {sda_s[1:0], BUS.sda};
			sda_f <= eer_agree(sda_s, sda_f);
			qcnt  <= (tick || state != MS_RUN) ? QTR_CYCLES - 8'h01 : qcnt - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command sequencer and bit engine

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state     <= MS_WAIT;
			kind      <= KIND_RECOVER;
			auto_run  <= 1'b1;
			step      <= 3'h0;
			quarter   <= 2'h0;
			bitn      <= 4'h0;
			timer     <= 32'(INIT_CYC);
			c_addr    <= BYTE_ZERO;
			c_data    <= BYTE_ZERO;
			rxb       <= BYTE_ZERO;
			nack      <= 1'b0;
			scl       <= 1'b1;
			sda_oe_n  <= 1'b1;
			CMD_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_DATA  <= BYTE_ZERO;
			RSP_NACK  <= 1'b0;
		end else if (CLK_EN) begin
			RSP_VALID <= 1'b0;
			case (state)
			MS_WAIT: begin
				// slave is deaf while it initialises; then recover once
				if (timer == 32'h0) begin
					state <= MS_RUN;
				end else begin
					timer <= timer - 32'h1;
				end
			end
			MS_IDLE: begin
				if (CMD_VALID && CMD_READY) begin
					state     <= MS_RUN;
					kind      <= CMD_KIND;
					c_addr    <= CMD_ADDR;
					c_data    <= CMD_DATA;
					step      <= 3'h0;
					quarter   <= 2'h0;
					bitn      <= 4'h0;
					nack      <= 1'b0;
					CMD_READY <= 1'b0;
				end
			end
			MS_RUN: begin
				if (act == ACT_END) begin
					state     <= MS_IDLE;
					auto_run  <= 1'b0;
					CMD_READY <= 1'b1;
					RSP_VALID <= ~auto_run;
					RSP_DATA  <= rxb;
					RSP_NACK  <= nack;
				end else if (tick) begin
					quarter <= quarter + 2'h1;
					case (act)
					ACT_START: begin
						// release while scl low, then fall with scl high
						case (quarter)
						2'h0:    sda_oe_n <= 1'b1;
						2'h1:    scl      <= 1'b1;
						2'h2:    sda_oe_n <= 1'b0;
						default: scl      <= 1'b0;
						endcase
					end
					ACT_STOP: begin
						case (quarter)
						2'h0:    sda_oe_n <= 1'b0;
						2'h1:    scl      <= 1'b1;
						2'h2:    sda_oe_n <= 1'b1;
						default: scl      <= 1'b1;
						endcase
					end
					default: begin
						case (quarter)
						2'h0: begin
							// dummies keep sda released so a stuck slave lets go
							if (act == ACT_TX && bitn != BIT_ACK) begin
								sda_oe_n <= txb[3'(4'h7 - bitn)];
							end else begin
								sda_oe_n <= 1'b1;
							end
						end
						2'h1: scl <= 1'b1;
						2'h2: begin
							if (act == ACT_RX && bitn != BIT_ACK) begin
								rxb <= {rxb[6:0], sda_f};
							end
							if (act == ACT_TX && bitn == BIT_ACK && sda_f) begin
								nack <= 1'b1;
							end
						end
						default: begin
							scl  <= 1'b0;
							bitn <= bitn + 4'h1;
						end
						endcase
					end
					endcase
					// last quarter of the action: advance the sequence
					if (quarter == 2'h3 && (act == ACT_START || act == ACT_STOP ||
					    bitn == DUMMY_LAST)) begin
						bitn <= 4'h0;
						if (act == ACT_TX && nack) begin
							step <= (kind == KIND_WRITE) ? 3'h4 : 3'h6;
						end else begin
							step <= step + 3'h1;
						end
					end
				end
			end
			default: state <= MS_IDLE;
			endcase
		end
	end

	// output flops; data output is a constant low
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sda_o <= 1'b0;
		end else if (CLK_EN) begin
			sda_o <= 1'b0;
		end
	end

	assign BUS.scl           = scl;
	assign BUS.host_sda_o    = sda_o;
	assign BUS.host_sda_oe_n = sda_oe_n;

endmodule

/* bench/eer_asserts.sv */
`timescale 1ns/1ps
module eer_asserts #(
	parameter int unsigned INIT_CYC = 20
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// bus wires
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic sda
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////////////////////////////////////
	// cycles since reset, saturating at the init length
	logic [31:0] init_cnt;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			init_cnt <= '0;
		else if (init_cnt < INIT_CYC)
			init_cnt <= init_cnt + 32'h1;
	end

	// run of scl rises seeing sda high; a low bit or ack breaks it
	logic       scl_q;
	logic [3:0] high_run;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_q    <= 1'b1;
			high_run <= 4'h0;
		end else begin
			scl_q <= scl;
			if (scl && !scl_q)
				high_run <= !sda ? 4'h0 : (high_run == 4'hF ? high_run : high_run + 4'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus conditions
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	sequence s_tenth_rise;
		scl && !scl_q && high_run >= 4'h9;
	endsequence

	a_dev_low_only: assert property (!dev_sda_oe_n |-> !dev_sda_o)
		else $error("device drives data line high");
	a_host_low_only: assert property (!host_sda_oe_n |-> !host_sda_o)
		else $error("host drives data line high");
	// margin of two cycles for the host's start-up latency
	a_dev_init_quiet: assert property (init_cnt < INIT_CYC - 2 |-> dev_sda_oe_n)
		else $error("device drives bus during init");
	a_host_init_quiet: assert property (init_cnt < INIT_CYC - 2 |-> scl && host_sda_oe_n)
		else $error("host active during init");
	a_start_free: assert property (scl && $fell(host_sda_oe_n) |-> dev_sda_oe_n)
		else $error("host start while device holds line");
	a_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device drive changed with clock high");
	a_dummy_release: assert property (s_tenth_rise |-> dev_sda_oe_n)
		else $error("device drives after nine high clocks");
	a_stop_idle: assert property (s_stop |-> ##1 dev_sda_oe_n [*8])
		else $error("device drives after stop");
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
	import eer_pkg::*;
	localparam int unsigned INIT = 20;
	localparam int unsigned WCYC = 6000;

	logic       sys_clk    = 1'b0;
	logic       rst_n      = 1'b0;
	logic       cmd_valid  = 1'b0;
	logic [1:0] cmd_kind   = KIND_RECOVER;
	logic [7:0] cmd_addr   = 8'h00;
	logic [7:0] cmd_data   = 8'h00;
	logic       low_supply = 1'b0;
	logic       cmd_ready, rsp_valid, rsp_nack, ready, busy, wr_done, wr_cancel;
	logic       ready2, busy2, wr_done2, ack;
	logic [7:0] rsp_data;
	int         err_count = 0;
	int         total_checks = 0;
	int         n_done = 0;
	int         n_cancel = 0;
	int         n_done2 = 0;

	eer_if bus ();
	eer_if bus2 ();

	// 100 MHz system clock
	always #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	// host and device face each other; a second device is bit-banged
	eer_host #(.INIT_CYC(INIT)) u_eer_host (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(1'b1),
		.BUS(bus), .CMD_VALID(cmd_valid), .CMD_KIND(cmd_kind), .CMD_ADDR(cmd_addr),
		.CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .RSP_NACK(rsp_nack));
	eer_dev #(.INIT_CYC(INIT), .WRITE_CYC(WCYC)) u_eer_dev (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.CLK_EN(1'b1), .BUS(bus), .LOW_SUPPLY(low_supply), .READY(ready), .BUSY(busy),
		.WR_DONE(wr_done), .WR_CANCEL(wr_cancel));
	eer_dev #(.INIT_CYC(INIT), .WRITE_CYC(WCYC)) u_eer_dev_2 (.SYS_CLK(sys_clk),
		.RST_N(rst_n), .CLK_EN(1'b1), .BUS(bus2), .LOW_SUPPLY(1'b0), .READY(ready2),
		.BUSY(busy2), .WR_DONE(wr_done2), .WR_CANCEL());
	eer_asserts #(.INIT_CYC(INIT)) u_eer_asserts (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.scl(bus.scl), .host_sda_o(bus.host_sda_o), .host_sda_oe_n(bus.host_sda_oe_n),
		.dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n), .sda(bus.sda));

	// pulse counters, so a one-cycle strobe is never missed
	always @(posedge sys_clk) begin
		if (wr_done) n_done++;
		if (wr_cancel) n_cancel++;
		if (wr_done2) n_done2++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	function automatic logic flag(input int sel);
		case (sel)
			0: return cmd_ready;
			1: return rsp_valid;
			2: return ready2;
			3: return !busy;
			default: return !busy2;
		endcase
	endfunction

	// bounded wait; a hang ends the run as a failure
	task automatic wait_on(input int sel, input int lim);
		for (int i = 0; i < lim && flag(sel) !== 1'b1; i++)
			step;
		if (flag(sel) !== 1'b1) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
			complete_run;
		end
	endtask

	task automatic host_cmd(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
		wait_on(0, 100);
		cmd_kind  = k;
		cmd_addr  = a;
		cmd_data  = d;
		cmd_valid = 1'b1;
		step;
		cmd_valid = 1'b0;
		wait_on(1, 6000);
	endtask

	////////////////////////////////////////////////////////////////////////
	// bit-banged master on the second bus: one call is one 25-cycle quarter
	task automatic bb(input logic c, input logic d);
		bus2.scl           = c;
		bus2.host_sda_oe_n = d;
		repeat (25) step;
	endtask

	task automatic bb_start;
		bb(1'b0, 1'b1);
		bb(1'b1, 1'b1);
		bb(1'b1, 1'b0);
		bb(1'b0, 1'b0);
	endtask

	task automatic bb_stop;
		bb(1'b0, 1'b0);
		bb(1'b1, 1'b0);
		bb(1'b1, 1'b1);
	endtask

	task automatic bb_bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			bb(1'b0, b[i]);
			bb(1'b1, b[i]);
			bb(1'b0, b[i]);
		end
	endtask

	// whole byte plus ack clock; ack holds the level seen with scl high
	task automatic bb_byte(input logic [7:0] b);
		bb_bits(b, 8);
		bb(1'b0, 1'b1);
		bb(1'b1, 1'b1);
		ack = bus2.sda;
		bb(1'b0, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_init;
		chk(ready, 1'b0);
		wait_on(0, 3000);
		chk(ready, 1'b1);
	endtask

	// write, then poll while busy, then read back
	task automatic t_write;
		host_cmd(KIND_WRITE, 8'h3C, 8'hA5);
		chk(rsp_nack, 1'b0);
		host_cmd(KIND_READ, 8'h3C, 8'h00);
		chk(rsp_nack, 1'b1);
		chk(busy, 1'b1);
		wait_on(3, 8000);
		chk(8'(n_done), 8'h01);
		host_cmd(KIND_READ, 8'h3C, 8'h00);
		chk(rsp_nack, 1'b0);
		chk(rsp_data, 8'hA5);
	endtask

	task automatic t_low_supply;
		low_supply = 1'b1;
		host_cmd(KIND_WRITE, 8'h3C, 8'h5A);
		chk(8'(n_cancel), 8'h01);
		chk(busy, 1'b0);
		low_supply = 1'b0;
		host_cmd(KIND_READ, 8'h3C, 8'h00);
		chk(rsp_data, 8'hA5);
	endtask

	// dummy write and a stop inside a data byte must not write
	task automatic t_dev_stops;
		wait_on(2, 200);
		bb_start;
		bb_byte(8'hA0);
		chk(ack, 1'b0);
		bb_byte(8'h10);
		bb_stop;
		chk(busy2, 1'b0);
		bb_start;
		bb_byte(8'hA0);
		bb_byte(8'h10);
		bb_bits(8'h77, 4);
		bb_stop;
		chk(busy2, 1'b0);
		chk(8'(n_done2), 8'h00);
	endtask

	// start in mid-byte aborts; the following full write commits
	task automatic t_dev_abort;
		bb_start;
		bb_byte(8'hA0);
		bb_byte(8'h10);
		bb_bits(8'h77, 3);
		bb_start;
		bb_byte(8'hA0);
		chk(ack, 1'b0);
		bb_byte(8'h10);
		bb_byte(8'h77);
		bb_stop;
		chk(busy2, 1'b1);
		wait_on(4, 8000);
		chk(8'(n_done2), 8'h01);
	endtask

	// device holding a zero read bit is freed by nine high dummies
	task automatic t_dev_recover;
		bb_start;
		bb_byte(8'hA0);
		bb_byte(8'h10);
		bb_start;
		bb_byte(8'hA1);
		chk(bus2.sda, 1'b0);
		for (int i = 0; i < 9; i++) begin
			bb(1'b1, 1'b1);
			bb(1'b0, 1'b1);
		end
		chk(bus2.sda, 1'b1);
		bb_start;
		bb_stop;
		bb_start;
		bb_byte(8'hA0);
		chk(ack, 1'b0);
		bb_stop;
		chk(bus2.sda, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		bus2.scl           = 1'b1;
		bus2.host_sda_o    = 1'b0;
		bus2.host_sda_oe_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		t_init;
		t_write;
		t_low_supply;
		t_dev_stops;
		t_dev_abort;
		t_dev_recover;
		complete_run;
	end
endmodule
